// ==== core/banked_register_file_decode.v ====
/*
 holds the banked register decode: pointer register, overlay of the lowest sixteen
 addresses by the expansion bank space, working-register address forming and the
 expansion registers of banks c and f; the standard file sits in standard_reg_mem.
 assumes the cpu issues at most one access per cycle, with read data one cycle later.
*/
// How it works
// RULE_01: sixteen banks of up to 256 bytes, each split into sixteen groups of sixteen.
// RULE_02: pointer low nibble picks the bank, high nibble picks the working group.
// RULE_03: the low-nibble code is the bank number, 0 standard through f.
// RULE_04: with a nonzero bank, addresses 00h to 0fh reach that bank's group 0.
// RULE_05: addresses 10h and up always reach the standard registers.
// RULE_06: only banks 0, c and f exist, banks c and f only in group 0.
// RULE_07: a 4-bit working operand joins the pointer high nibble into an 8-bit address.
// RULE_08: working operands in nonzero groups reach standard registers of that group.
// RULE_09: bank c holds serial compare, data and control at 00h, 01h, 02h.
// RULE_10: bank f holds port control, stop mode and watchdog mode at 00h, 0bh, 0fh.
// RULE_11: bank 0 holds ports at 00h-03h, general registers to efh, control from f0h.
// RULE_12: only a write to fdh changes the bank, and fdh is reachable in every bank.
// RULE_13: software reselects bank 0 before it needs ports or low general registers.
// RULE_14: a pointer read returns the current bank in its low four bits.
// RULE_15: reserved bank locations ignore writes and read as all ones.
`default_nettype none
`include "bank_decode_map.vh"

module banked_register_file_decode (
   input wire i_clock,
   input wire i_rstn,
   input wire i_rd,
   input wire i_wr,
   input wire i_working,
   input wire [7:0] i_addr,
   input wire [7:0] i_wdata,
   output reg [7:0] o_rdata,
   output wire [7:0] o_bank_group_pointer,
   output wire [7:0] o_serial_compare_reg,
   output wire [7:0] o_serial_txrx_data_reg,
   output wire [7:0] o_serial_control_reg,
   output wire [7:0] o_port_control_reg,
   output wire [7:0] o_stop_mode_reg,
   output wire [7:0] o_watchdog_mode_reg
);
   // read source, captured with each read
   localparam [1:0] SRC_MEM = 2'h0;
   localparam [1:0] SRC_PTR = 2'h1;
   localparam [1:0] SRC_EXP = 2'h2;
   localparam [1:0] SRC_RSV = 2'h3;

   // slots of the implemented expansion registers
   localparam [2:0] SLOT_SER_COMPARE = 3'h0;
   localparam [2:0] SLOT_SER_DATA = 3'h1;
   localparam [2:0] SLOT_SER_CONTROL = 3'h2;
   localparam [2:0] SLOT_PORT_CONTROL = 3'h3;
   localparam [2:0] SLOT_STOP_MODE = 3'h4;
   localparam [2:0] SLOT_WATCHDOG = 3'h5;
   localparam SLOTS = 6;

   reg [7:0] bank_group_pointer_ff;
   reg [7:0] exp_rdata_ff;
   reg [7:0] nxt_exp_rdata;
   reg [1:0] src_ff;
   reg [1:0] nxt_src;
   reg [7:0] eff_addr;
   reg [3:0] bank;
   reg [3:0] group;
   reg [3:0] offset;
   reg overlay;
   reg ptr_hit;
   reg exp_hit;
   reg [2:0] exp_idx;
   reg mem_wr;
   reg ptr_wr;
   wire [7:0] mem_rdata;
   wire [8*SLOTS-1:0] exp_flat;
   wire [SLOTS-1:0] exp_we;

   // pointer fields and effective address
   always @* begin
      bank = bank_group_pointer_ff[`BANK_MSB:`BANK_LSB]; // [RULE_02] [RULE_03]
      group = bank_group_pointer_ff[`GROUP_MSB:`GROUP_LSB]; // [RULE_02]
      if (i_working) begin
         eff_addr = {group, i_addr[3:0]}; // [RULE_07] [RULE_08]
      end else begin
         eff_addr = i_addr;
      end
      offset = eff_addr[3:0];
      // only the lowest sixteen addresses are overlaid
      overlay = (eff_addr[7:4] == `OVERLAY_TOP) && (bank != `BANK_STANDARD); // [RULE_04] [RULE_05]
      ptr_hit = (eff_addr == `POINTER_ADDR); // [RULE_12]
   end

   // implemented expansion registers; every other overlaid byte is reserved
   always @* begin
      exp_hit = 1'b0;
      exp_idx = SLOT_SER_COMPARE;
      case (bank)
         `BANK_SERIAL: begin // [RULE_09]
            case (offset)
               `SER_COMPARE_ADDR: begin
                  exp_hit = overlay;
                  exp_idx = SLOT_SER_COMPARE;
               end
               `SER_DATA_ADDR: begin
                  exp_hit = overlay;
                  exp_idx = SLOT_SER_DATA;
               end
               `SER_CONTROL_ADDR: begin
                  exp_hit = overlay;
                  exp_idx = SLOT_SER_CONTROL;
               end
               default: begin
                  exp_hit = 1'b0;
                  exp_idx = SLOT_SER_COMPARE;
               end
            endcase
         end
         `BANK_CONTROL: begin // [RULE_10]
            case (offset)
               `PORT_CONTROL_ADDR: begin
                  exp_hit = overlay;
                  exp_idx = SLOT_PORT_CONTROL;
               end
               `STOP_MODE_ADDR: begin
                  exp_hit = overlay;
                  exp_idx = SLOT_STOP_MODE;
               end
               `WATCHDOG_ADDR: begin
                  exp_hit = overlay;
                  exp_idx = SLOT_WATCHDOG;
               end
               default: begin
                  exp_hit = 1'b0;
                  exp_idx = SLOT_SER_COMPARE;
               end
            endcase
         end
         default: begin // [RULE_06]
            exp_hit = 1'b0;
            exp_idx = SLOT_SER_COMPARE;
         end
      endcase
   end

   // bank 0 memory takes every write that is neither overlaid nor the pointer
   always @* begin
      ptr_wr = i_wr && ptr_hit; // [RULE_12]
      mem_wr = i_wr && !overlay && !ptr_hit; // [RULE_11] [RULE_15]
   end

   // read source and the data of the non-memory sources
   always @* begin
      if (ptr_hit) begin
         nxt_src = SRC_PTR;
         nxt_exp_rdata = bank_group_pointer_ff; // [RULE_14]
      end else if (exp_hit) begin
         nxt_src = SRC_EXP;
         nxt_exp_rdata = exp_flat[{exp_idx, 3'h0} +: 8];
      end else if (overlay) begin
         nxt_src = SRC_RSV;
         nxt_exp_rdata = `RESERVED_READ; // [RULE_06] [RULE_15]
      end else begin
         nxt_src = SRC_MEM;
         nxt_exp_rdata = `RESERVED_READ;
      end
   end

   standard_reg_mem u_mem (
      .i_clock(i_clock),
      .i_wr(mem_wr),
      .i_addr(eff_addr),
      .i_wdata(i_wdata),
      .o_rdata(mem_rdata)
   );

   always @(posedge i_clock) begin
      if (!i_rstn) begin
         bank_group_pointer_ff <= `POINTER_RESET;
      end else if (ptr_wr) begin
         bank_group_pointer_ff <= i_wdata; // [RULE_12]
      end
   end

   // one byte register per implemented expansion slot
   genvar g;
   generate
      for (g = 0; g < SLOTS; g = g + 1) begin : g_exp
         localparam [2:0] IDX = g;
         reg [7:0] slot_ff;
         assign exp_we[g] = i_wr && exp_hit && (exp_idx == IDX);
         always @(posedge i_clock) begin
            if (!i_rstn) begin
               slot_ff <= `EXP_RESET;
            end else if (exp_we[g]) begin
               slot_ff <= i_wdata; // [RULE_01]
            end
         end
         assign exp_flat[8*g+7:8*g] = slot_ff;
      end
   endgenerate

   always @(posedge i_clock) begin
      if (!i_rstn) begin
         exp_rdata_ff <= 8'h00;
         src_ff <= SRC_EXP;
      end else if (i_rd) begin
         exp_rdata_ff <= nxt_exp_rdata;
         src_ff <= nxt_src;
      end
   end

   // memory read data are already registered inside the memory
   always @* begin
      case (src_ff)
         SRC_MEM: o_rdata = mem_rdata;
         SRC_PTR: o_rdata = exp_rdata_ff;
         SRC_EXP: o_rdata = exp_rdata_ff;
         SRC_RSV: o_rdata = `RESERVED_READ; // [RULE_15]
         default: o_rdata = exp_rdata_ff;
      endcase
   end

   assign o_bank_group_pointer = bank_group_pointer_ff;
   assign o_serial_compare_reg = exp_flat[7:0];
   assign o_serial_txrx_data_reg = exp_flat[15:8];
   assign o_serial_control_reg = exp_flat[23:16];
   assign o_port_control_reg = exp_flat[31:24];
   assign o_stop_mode_reg = exp_flat[39:32];
   assign o_watchdog_mode_reg = exp_flat[47:40];
endmodule // banked_register_file_decode

`default_nettype wire

// ==== shared/bank_decode_map.vh ====
/*
 holds the address map, field positions and reset values of the banked register decode.
 assumes inclusion by bare name from the core files.
*/
`ifndef BANK_DECODE_MAP_VH
`define BANK_DECODE_MAP_VH

`define POINTER_ADDR 8'hfd
`define POINTER_RESET 8'h00
`define BANK_LSB 0
`define BANK_MSB 3
`define GROUP_LSB 4
`define GROUP_MSB 7
`define BANK_STANDARD 4'h0
`define BANK_SERIAL 4'hc
`define BANK_CONTROL 4'hf
`define OVERLAY_TOP 4'h0
`define PORT_LAST 8'h03
`define GPR_LAST 8'hef
`define CTRL_FIRST 8'hf0
`define SER_COMPARE_ADDR 4'h0
`define SER_DATA_ADDR 4'h1
`define SER_CONTROL_ADDR 4'h2
`define PORT_CONTROL_ADDR 4'h0
`define STOP_MODE_ADDR 4'hb
`define WATCHDOG_ADDR 4'hf
`define RESERVED_READ 8'hff
`define EXP_RESET 8'h00

`endif

// ==== core/standard_reg_mem.v ====
/*
 holds the 256-byte standard register file (bank 0) as a small memory.
 assumes one clock, synchronous write, registered read data.
*/
`default_nettype none

module standard_reg_mem (
   input wire i_clock,
   input wire i_wr,
   input wire [7:0] i_addr,
   input wire [7:0] i_wdata,
   output reg [7:0] o_rdata
);
   reg [7:0] mem [0:255];

   always @(posedge i_clock) begin
      if (i_wr) begin
         mem[i_addr] <= i_wdata;
      end
      o_rdata <= mem[i_addr];
   end
endmodule // standard_reg_mem

`default_nettype wire

// ==== testbench/bank_chk.sv ====
/* checker on the banked decode ports; bound onto the decode top, one clock domain */
`default_nettype none
module bank_chk(input wire logic i_clock, i_rstn, i_rd, i_wr, i_working,
   input wire logic [7:0] i_addr, i_wdata, o_rdata, o_bank_group_pointer,
   input wire logic [7:0] o_serial_control_reg, o_watchdog_mode_reg);
   timeunit 1ns;
   timeprecision 1ps;
   logic [7:0] e, p;
   logic sc, rsv;
   assign p = o_bank_group_pointer;
   assign e = i_working ? {p[7:4], i_addr[3:0]} : i_addr;
   assign sc = e == 8'h02 && p[3:0] == 4'hc;
   assign rsv = e < 8'h10 && p[3:0] != 4'h0 && p[3:0] != 4'hc && p[3:0] != 4'hf;
   default clocking @(posedge i_clock); endclocking
   default disable iff (!i_rstn);
   ptr_write_a: assert property (i_wr && e == 8'hfd |=> p == $past(i_wdata))
      else $error("ptr write");
   ptr_hold_a: assert property (!(i_wr && e == 8'hfd) |=> $stable(p))
      else $error("ptr moved");
   ptr_read_a: assert property (i_rd && e == 8'hfd |=> o_rdata == $past(p))
      else $error("ptr read");
   sc_write_a: assert property (i_wr && sc |=> o_serial_control_reg == $past(i_wdata))
      else $error("sc write");
   sc_keep_a: assert property (!(i_wr && sc) |=> $stable(o_serial_control_reg))
      else $error("sc moved");
   sc_read_a: assert property (i_rd && sc |=> o_rdata == $past(o_serial_control_reg))
      else $error("sc read");
   wd_write_a: assert property (i_wr && e == 8'h0f && p[3:0] == 4'hf
      |=> o_watchdog_mode_reg == $past(i_wdata)) else $error("wd write");
   rsv_read_a: assert property (i_rd && rsv |=> o_rdata == 8'hff)
      else $error("rsv read");
   cover property (i_wr && sc);
   cover property (i_rd && rsv);
   cover property (i_working && i_wr && p[3:0] == 4'hf);
endmodule // bank_chk
bind banked_register_file_decode bank_chk u_chk(.*);
`default_nettype wire

// ==== testbench/cpu_model.sv ====
/* cpu side model, one byte access a call; the decode takes requests on the rising edge */
`default_nettype none
module cpu_model(input wire logic i_clock, input wire logic [7:0] i_rdata,
   output logic o_rd, o_wr, o_working, output logic [7:0] o_addr, o_wdata);
   timeunit 1ns;
   timeprecision 1ps;
   initial {o_rd, o_wr, o_working, o_addr, o_wdata} = 19'h0;
   task automatic acc(input logic w, k, input logic [7:0] a, d, output logic [7:0] q);
      @(posedge i_clock) {o_rd, o_wr, o_working, o_addr, o_wdata} <= {!w, w, k, a, d};
      @(posedge i_clock) {o_rd, o_wr, o_wdata} <= {2'h0, ~d};
      #1 q = i_rdata;
   endtask
endmodule // cpu_model
`default_nettype wire

// ==== testbench/tb.sv ====
/* bench for the banked decode via the cpu model; decode, memory, checker come first */
`default_nettype none
module tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic i_clock, i_rstn, i_rd, i_wr, i_working;
   logic [7:0] i_addr, i_wdata, o_rdata, o_bank_group_pointer, o_serial_compare_reg, q;
   logic [7:0] o_serial_txrx_data_reg, o_serial_control_reg, o_port_control_reg;
   logic [7:0] o_stop_mode_reg, o_watchdog_mode_reg;
   int errors, comparisons;
   cpu_model u_cpu(.i_clock, .i_rdata(o_rdata), .o_rd(i_rd), .o_wr(i_wr),
      .o_working(i_working), .o_addr(i_addr), .o_wdata(i_wdata));
   banked_register_file_decode u_dut(.*);
   task x(input logic w, input logic [7:0] a, d, input logic k = 1'h0);
      u_cpu.acc(w, k, a, d, q);
      if (!w) comparisons++;
      if (!w && q !== d) begin
         errors++;
         $display("[ERR] %0t read %h want %h", $time, q, d);
      end
   endtask
   task t_banks;
      x(1'h1, 8'h03, 8'h5a);
      x(1'h1, 8'hfd, 8'h0c);
      x(1'h1, 8'h02, 8'h33, 1'h1);
      x(1'h0, 8'h02, 8'h33);
      x(1'h1, 8'h03, 8'h77);
      x(1'h0, 8'h03, 8'hff);
      x(1'h1, 8'hfd, 8'hff);
      x(1'h1, 8'h00, 8'h44, 1'h1);
      x(1'h0, 8'hf0, 8'h44);
      x(1'h1, 8'h0f, 8'h99);
      x(1'h1, 8'hfd, 8'h00);
      x(1'h0, 8'h03, 8'h5a);
   endtask
   task t_codes;
      for (int b = 1; b < 16; b++) begin
         x(1'h1, 8'hfd, 8'(b));
         x(1'h0, 8'hfd, 8'(b));
         x(1'h1, 8'h00, 8'(b + 32));
         x(1'h0, 8'h00, b == 12 || b == 15 ? 8'(b + 32) : 8'hff);
      end
   endtask
   task c(input logic [7:0] got, want);
      comparisons++;
      if (got !== want) begin
         errors++;
         $display("[ERR] %0t output %h want %h", $time, got, want);
      end
   endtask
   task t_outputs;
      x(1'h1, 8'h10, 8'h66);
      x(1'h1, 8'hfd, 8'h0c);
      x(1'h1, 8'h00, 8'h11);
      x(1'h1, 8'h01, 8'h22);
      x(1'h1, 8'h02, 8'h23);
      c(o_serial_compare_reg, 8'h11);
      c(o_serial_txrx_data_reg, 8'h22);
      c(o_serial_control_reg, 8'h23);
      x(1'h0, 8'h10, 8'h66);
      x(1'h1, 8'hfd, 8'h0f);
      x(1'h1, 8'h00, 8'h31);
      x(1'h1, 8'h0b, 8'h32);
      x(1'h1, 8'h0f, 8'h33);
      c(o_port_control_reg, 8'h31);
      c(o_stop_mode_reg, 8'h32);
      c(o_watchdog_mode_reg, 8'h33);
      c(o_serial_compare_reg, 8'h11);
      c(o_bank_group_pointer, 8'h0f);
      x(1'h1, 8'hfd, 8'h00);
   endtask
   task summarize;
      $display("errors %0d comparisons %0d", errors, comparisons);
      if (errors == 0 && comparisons > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   initial begin
      i_clock = 1'h0;
      forever #20 i_clock = ~i_clock;
   end
   initial begin
      #20000 errors++;
      summarize;
   end
   initial begin
      i_rstn = 1'h0;
      repeat (8) @(posedge i_clock);
      i_rstn <= 1'h1;
      t_banks;
      t_codes;
      t_outputs;
      summarize;
   end
endmodule // tb
`default_nettype wire
